// >>> include/odc_pkg.sv
// odc_pkg: constants and types shared by both ends of the octal converter serial link
// assumes: 16-bit frames, msb first, eight 12-bit channels
package odc_pkg;
   localparam int ODC_FRAME_BITS = 16;
   localparam int ODC_CMD_BITS = 4;
   localparam int ODC_DATA_BITS = 12;
   localparam int ODC_CHANNELS = 8;
   localparam int ODC_CMD_MSB = 15;
   localparam int ODC_CMD_LSB = 12;
   localparam int ODC_MASK_MSB = 11;
   localparam int ODC_MASK_LSB = 4;
   localparam int ODC_MODE_HI = 3;
   localparam int ODC_MODE_LO = 2;
   localparam int ODC_CNT_W = 5;
   localparam int ODC_SCLK_DIV = 4;
   localparam logic [3:0] ODC_CMD_NOP = 4'h0;
   localparam logic [3:0] ODC_CMD_RESET = 4'h1;
   localparam logic [3:0] ODC_CMD_IN1 = 4'h2;
   localparam logic [3:0] ODC_CMD_IN8 = 4'h9;
   localparam logic [3:0] ODC_CMD_THRU_LO = 4'ha;
   localparam logic [3:0] ODC_CMD_THRU_HI = 4'hb;
   localparam logic [3:0] ODC_CMD_THRU_ALL = 4'hc;
   localparam logic [3:0] ODC_CMD_IN_ALL = 4'hd;
   localparam logic [3:0] ODC_CMD_LOAD_OUT = 4'he;
   localparam logic [3:0] ODC_CMD_POWER = 4'hf;
   localparam logic [11:0] ODC_DATA_ZERO = 12'h000;
   typedef enum logic [1:0] {
      ODC_PWR_ACTIVE = 2'b11,
      ODC_PWR_HIZ = 2'b01,
      ODC_PWR_R1K = 2'b10,
      ODC_PWR_R100K = 2'b00
   } odc_pwr_type;
endpackage : odc_pkg

// >>> include/odc_if.sv
// odc_if: three-wire serial link plus clear and chained output
// assumes: host drives cs, sclk, din, clear; device drives chained out
`timescale 1ns/1ps
interface odc_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic clear_n_input;
   logic dout;
   modport device (input cs_n, input sclk, input din, input clear_n_input, output dout);
   modport host (output cs_n, output sclk, output din, output clear_n_input, input dout);
endinterface : odc_if

// >>> core/odc_device.sv
// odc_device: control logic of the eight channel converter, link side
// assumes: link pins asynchronous to mclk_i, sampled by two flip-flops;
// sclk period far longer than four mclk periods
//
// Overview of operation
// - short frame dropped without any effect; here its bits still shift through to the chained output
// - frame starts at chip select falling
// - either clock idle level accepted
// - input and output registers per channel
// - mode 11 powers masked channels up
// - mode 01 floats masked channels
// - mode 10 grounds through low resistor
// - mode 00 grounds through high resistor
// - chained output is input delayed 16
// - chained output moves on clock falling
// - clear empties registers, high termination
// - clear acts at any time asynchronously
// - clear abandons a word in flight
// - power on clears and shuts channels
// - after power up everything reads zero
// - host holds select 16 clocks per device
// - select rising executes shift register contents
// - host fills other slots with no-op
// - sixteen bits msb first, execute on rise
// - no-op, reset, single input loads
// - write-through groups and load all inputs
// - mask copies input to output registers
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module odc_device #(
   parameter int CHANNELS = odc_pkg::ODC_CHANNELS
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   odc_if.device link,
   output logic [odc_pkg::ODC_CHANNELS*odc_pkg::ODC_DATA_BITS-1:0] out_data_o,
   output logic [odc_pkg::ODC_CHANNELS*2-1:0] out_state_o,
   output logic [odc_pkg::ODC_CHANNELS*odc_pkg::ODC_DATA_BITS-1:0] in_data_o
);
   import odc_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   // ports are sized from the package, so only eight channels fit
   if (CHANNELS != ODC_CHANNELS) begin : g_bad_channels
      $error("odc_device: channel count fixed at eight");
   end
   if (ODC_CMD_BITS + ODC_DATA_BITS != ODC_FRAME_BITS) begin : g_bad_frame
      $error("odc_device: command and payload must fill the frame");
   end
   if ((1 << ODC_CNT_W) <= ODC_FRAME_BITS) begin : g_bad_count
      $error("odc_device: bit counter too narrow for a frame");
   end
   if (ODC_MASK_MSB - ODC_MASK_LSB + 1 != ODC_CHANNELS) begin : g_bad_mask
      $error("odc_device: mask field must hold one bit per channel");
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [2:0] prev_q;
   logic clr_meta_q;
   logic clr_n_q;

   // clear: asserts asynchronously, releases through two flops
   always_ff @(posedge mclk_i or negedge rst_n_i or negedge link.clear_n_input) begin
      if (!rst_n_i || !link.clear_n_input) begin
         clr_meta_q <= 1'b0;
         clr_n_q <= 1'b0;
      end else begin
         clr_meta_q <= 1'b1;
         clr_n_q <= clr_meta_q;
      end
   end

   // registers reset from the synchronised clear: it still drops at once,
   // but lets go on a clock edge, so no flop leaves reset mid cycle
   wire arst_n = clr_n_q;

   always_ff @(posedge mclk_i or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= 3'h1;
         sync2_q <= 3'h1;
         prev_q <= 3'h1;
      end else begin
         sync1_q <= {link.din, link.sclk, link.cs_n};
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   wire cs_s = sync2_q[0];
   wire sclk_s = sync2_q[1];
   wire din_s = sync2_q[2];
   wire cs_fall = prev_q[0] & ~cs_s;
   wire cs_rise = ~prev_q[0] & cs_s;
   // edges are only counted inside the frame, so idle level does not matter
   wire sclk_fall = prev_q[1] & ~sclk_s & ~cs_s & ~prev_q[0];

   // ------------------------------------------------------------
   // frame shifter and chain delay
   // ------------------------------------------------------------
   logic [ODC_FRAME_BITS-1:0] shift_q;
   logic [ODC_CNT_W-1:0] count_q;
   logic in_frame_q;
   logic dout_q;

   wire [ODC_CNT_W-1:0] count_inc = count_q + 5'h01;
   wire full_frame = (count_q >= 5'(ODC_FRAME_BITS));
   wire exec = cs_rise & in_frame_q & full_frame & clr_n_q;

   always_ff @(posedge mclk_i or negedge arst_n) begin
      if (!arst_n) begin
         shift_q <= '0;
         count_q <= '0;
         in_frame_q <= 1'b0;
         dout_q <= 1'b0;
      end else begin
         if (cs_fall) begin
            count_q <= '0;
            in_frame_q <= 1'b1;
         end else if (cs_rise) begin
            in_frame_q <= 1'b0;
         end else if (sclk_fall && in_frame_q) begin
            shift_q <= {shift_q[ODC_FRAME_BITS-2:0], din_s};
            // tap the new top bit: the chained out is the sixteenth stage itself,
            // so a downstream device sampling it on the next fall sees sixteen
            dout_q <= shift_q[ODC_FRAME_BITS-2];
            // saturate: longer frames execute their last sixteen bits
            if (!full_frame) count_q <= count_inc;
         end
      end
   end

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   wire [3:0] cmd = shift_q[ODC_CMD_MSB:ODC_CMD_LSB];
   wire [11:0] data = shift_q[ODC_DATA_BITS-1:0];
   wire [7:0] mask = shift_q[ODC_MASK_MSB:ODC_MASK_LSB];
   wire [1:0] mode = {shift_q[ODC_MODE_HI], shift_q[ODC_MODE_LO]};
   wire do_reset = exec & (cmd == ODC_CMD_RESET);
   wire do_power = exec & (cmd == ODC_CMD_POWER);

   // ------------------------------------------------------------
   // command helpers
   // ------------------------------------------------------------
   // write-through groups: lower half, upper half or every channel
   function automatic logic thru_hit(input logic [3:0] code, input int unsigned ch);
      logic lo_half;
      lo_half = (ch < ODC_CHANNELS / 2);
      return (code == ODC_CMD_THRU_ALL) ||
             ((code == ODC_CMD_THRU_LO) && lo_half) ||
             ((code == ODC_CMD_THRU_HI) && !lo_half);
   endfunction : thru_hit

   // single input loads: codes run up from the first channel's code
   function automatic logic single_hit(input logic [3:0] code, input int unsigned ch);
      return code == 4'(ODC_CMD_IN1 + ch);
   endfunction : single_hit

   // ------------------------------------------------------------
   // channel registers
   // ------------------------------------------------------------
   logic [ODC_DATA_BITS-1:0] in_q [ODC_CHANNELS];
   logic [ODC_DATA_BITS-1:0] out_q [ODC_CHANNELS];
   odc_pwr_type state_q [ODC_CHANNELS];

   for (genvar ch = 0; ch < ODC_CHANNELS; ch++) begin : g_ch
      wire single = single_hit(cmd, ch);
      wire thru = thru_hit(cmd, ch);
      wire ld_in = exec & (single | thru | (cmd == ODC_CMD_IN_ALL));
      wire ld_out_thru = exec & thru;
      wire ld_out_copy = exec & (cmd == ODC_CMD_LOAD_OUT) & mask[ch];
      wire pwr_hit = do_power & mask[ch];

      always_ff @(posedge mclk_i or negedge arst_n) begin
         if (!arst_n) begin
            in_q[ch] <= ODC_DATA_ZERO;
            out_q[ch] <= ODC_DATA_ZERO;
            state_q[ch] <= ODC_PWR_R100K;
         end else if (do_reset) begin
            in_q[ch] <= ODC_DATA_ZERO;
            out_q[ch] <= ODC_DATA_ZERO;
            state_q[ch] <= ODC_PWR_R100K;
         end else begin
            if (ld_in) in_q[ch] <= data;
            if (ld_out_thru) out_q[ch] <= data;
            else if (ld_out_copy) out_q[ch] <= in_q[ch];
            if (pwr_hit) state_q[ch] <= odc_pwr_type'(mode);
         end
      end

      // ---------------------------------------------------------
      // registered views for the analog section
      // ---------------------------------------------------------
      always_ff @(posedge mclk_i or negedge arst_n) begin
         if (!arst_n) begin
            out_data_o[ch*ODC_DATA_BITS +: ODC_DATA_BITS] <= ODC_DATA_ZERO;
            in_data_o[ch*ODC_DATA_BITS +: ODC_DATA_BITS] <= ODC_DATA_ZERO;
            out_state_o[ch*2 +: 2] <= ODC_PWR_R100K;
         end else begin
            out_data_o[ch*ODC_DATA_BITS +: ODC_DATA_BITS] <= out_q[ch];
            in_data_o[ch*ODC_DATA_BITS +: ODC_DATA_BITS] <= in_q[ch];
            out_state_o[ch*2 +: 2] <= state_q[ch];
         end
      end
   end

   assign link.dout = dout_q;
endmodule : odc_device

// >>> core/odc_host.sv
// odc_host: serial master that sends 16-bit words to one or more chained devices
// assumes: software port on mclk_i; sclk made by dividing mclk_i
`timescale 1ns/1ps
module odc_host #(
   parameter int DIV = odc_pkg::ODC_SCLK_DIV
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   odc_if.host link,
   input wire logic [1:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o
);
   import odc_pkg::*;

   // register offsets: 0 word fifo-less data, 1 control, 2 status, 3 captured chain out
   localparam logic [1:0] ADR_DATA = 2'h0;
   localparam logic [1:0] ADR_CTRL = 2'h1;
   localparam logic [1:0] ADR_STAT = 2'h2;
   localparam logic [1:0] ADR_RX = 2'h3;

   if (DIV < 2 || DIV > 255) begin : g_bad_div
      $error("odc_host: divider out of range");
   end

   // ------------------------------------------------------------
   // synchroniser and registers
   // ------------------------------------------------------------
   logic dout_m_q;
   logic dout_s_q;
   logic [15:0] tx_q;
   logic [15:0] rx_q;
   logic [7:0] div_q;
   logic [4:0] bit_q;
   logic busy_q;
   logic hold_q;
   logic cs_q;
   logic sclk_q;
   logic din_q;
   logic clr_q;

   wire wr_data = wr_i & (addr_i == ADR_DATA) & ~busy_q;
   wire wr_ctrl = wr_i & (addr_i == ADR_CTRL);
   wire tick = (div_q == 8'(DIV - 1));
   wire last_bit = (bit_q == 5'(ODC_FRAME_BITS - 1));

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dout_m_q <= 1'b0;
         dout_s_q <= 1'b0;
         rdata_o <= 16'h0000;
         tx_q <= 16'h0000;
         rx_q <= 16'h0000;
         div_q <= 8'h00;
         bit_q <= 5'h00;
         busy_q <= 1'b0;
         hold_q <= 1'b0;
         cs_q <= 1'b1;
         sclk_q <= 1'b0;
         din_q <= 1'b0;
         clr_q <= 1'b1;
      end else begin
         dout_m_q <= link.dout;
         dout_s_q <= dout_m_q;
         rdata_o <= 16'h0000;
         if (rd_i) begin
            case (addr_i)
               ADR_DATA: rdata_o <= tx_q;
               ADR_CTRL: rdata_o <= {14'h0000, hold_q, ~clr_q};
               ADR_STAT: rdata_o <= {15'h0000, busy_q};
               default: rdata_o <= rx_q;
            endcase
         end
         if (wr_ctrl) begin
            clr_q <= ~wdata_i[0];
            hold_q <= wdata_i[1];
            // releasing hold ends a chained frame
            if (!wdata_i[1] && !busy_q) cs_q <= 1'b1;
         end
         if (wr_data) begin
            tx_q <= wdata_i;
            busy_q <= 1'b1;
            cs_q <= 1'b0;
            din_q <= wdata_i[15];
            bit_q <= 5'h00;
            div_q <= 8'h00;
            sclk_q <= 1'b1;
         end else if (busy_q) begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
            if (tick) begin
               sclk_q <= ~sclk_q;
               if (sclk_q) begin
                  // falling edge: device samples din, capture chain out
                  rx_q <= {rx_q[14:0], dout_s_q};
               end else if (last_bit) begin
                  busy_q <= 1'b0;
                  if (!hold_q) cs_q <= 1'b1;
               end else begin
                  bit_q <= bit_q + 5'h01;
                  tx_q <= {tx_q[14:0], 1'b0};
                  din_q <= tx_q[14];
               end
            end
         end
      end
   end

   assign link.cs_n = cs_q;
   assign link.sclk = sclk_q;
   assign link.din = din_q;
   assign link.clear_n_input = clr_q;
endmodule : odc_host

// >>> test/odc_monitor.sv
// odc_monitor: wire checks on the link between host and device ends
// assumes: inputs taken straight from the odc_if wires, mclk_i domain
`timescale 1ns/1ps
module odc_monitor (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic clear_n_input,
   input wire logic dout
);
   logic sclk_q, clr_q;
   logic [15:0] hist_q;
   logic [3:0] since_q;
   logic [7:0] fcnt_q;
   wire logic fall = sclk_q & ~sclk;
   // a frame hit by clear is not judged: its tail may or may not shift
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_q <= 1'b0;
         clr_q <= 1'b0;
         hist_q <= '0;
         since_q <= 4'hf;
         fcnt_q <= '0;
      end else begin
         sclk_q <= sclk;
         clr_q <= !clear_n_input || (clr_q && !cs_n);
         if (!clear_n_input) hist_q <= '0;
         else if (fall && !cs_n && !clr_q) hist_q <= {hist_q[14:0], din};
         since_q <= fall ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
         fcnt_q <= cs_n ? 8'h0 : fcnt_q + {7'h0, fall};
      end
   end
   // ----------------------------------------
   // link properties
   // ----------------------------------------
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   reset_dout_a: assert property ($rose(rst_n_i) |-> !dout)
      else $error("chained out not low after reset");
   clear_dout_a: assert property (!clear_n_input |-> !dout)
      else $error("chained out not low during clear");
   dout_edge_a: assert property ($changed(dout) && clear_n_input && $past(clear_n_input)
      |-> since_q inside {[1:6]}) else $error("chained out moved off a clock fall");
   dout_delay_a: assert property (fall && !cs_n && !clr_q |-> dout == hist_q[15])
      else $error("chained out not sixteen clocks behind input");
   idle_sclk_a: assert property ($fell(sclk) |-> !cs_n)
      else $error("clock fall outside a frame");
   frame_len_a: assert property ($rose(cs_n) && !clr_q
      |-> fcnt_q != 0 && fcnt_q[3:0] == 4'h0)
      else $error("frame not a multiple of sixteen clocks");
   din_stable_a: assert property ($fell(sclk) |-> $stable(din))
      else $error("data moved at the sampling fall");
   cs_start_a: assert property ($fell(cs_n) |-> ##[1:16] $fell(sclk))
      else $error("no clock after select fell");
   cover property ($rose(cs_n) && fcnt_q == 8'h20);
   cover property ($fell(clear_n_input) && !cs_n);
   cover property (fall && !cs_n && dout);
endmodule : odc_monitor

// >>> test/octal_dac_serial_control_tb.sv
// octal_dac_serial_control_tb: host end drives device end over the link
// assumes: odc_pkg, odc_if, both ends and odc_monitor compiled before it
`timescale 1ns/1ps
module octal_dac_serial_control_tb;
   import odc_pkg::*;
   logic mclk, rst_n, wr_s, rd_s;
   logic [1:0] addr;
   logic [15:0] wdata, rdata, st, st_b;
   logic [15:0] rv, cw;
   logic [95:0] od, id, od_b, id_b;
   logic [207:0] q[$];
   logic [11:0] m_in[8], m_out[8];
   logic [1:0] m_st[8];
   int error_cnt = 0, num_checks = 0;
   odc_if lk();
   odc_if lb();
   odc_host u_odc_host (.mclk_i(mclk), .rst_n_i(rst_n), .link(lk.host), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata));
   odc_device u_odc_device (.mclk_i(mclk), .rst_n_i(rst_n), .link(lk.device),
      .out_data_o(od), .out_state_o(st), .in_data_o(id));
   // second device driven by hand, for frames the host end never makes
   odc_device u_odc_device_b (.mclk_i(mclk), .rst_n_i(rst_n), .link(lb.device),
      .out_data_o(od_b), .out_state_o(st_b), .in_data_o(id_b));
   odc_monitor u_odc_monitor (.mclk_i(mclk), .rst_n_i(rst_n), .cs_n(lk.cs_n), .sclk(lk.sclk),
      .din(lk.din), .clear_n_input(lk.clear_n_input), .dout(lk.dout));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [207:0] got, input logic [207:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t read %h exp %h", $time, got, exp);
      end
   endtask : chk_rd
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge mclk);
      wr_s <= 1'b0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge mclk);
      rd_s <= 1'b0;
      @(posedge mclk);
      d = rdata;
   endtask : rd
   task automatic wait_idle();
      logic [15:0] s;
      s = 16'h1;
      for (int n = 0; n < 400 && s[0] !== 1'b0; n++) rd(2'h2, s);
      if (s[0] !== 1'b0) begin
         error_cnt++;
         $display("MISMATCH t=%0t host stuck busy", $time);
         tally_and_finish();
      end
   endtask : wait_idle
   function automatic void apply(input logic [15:0] w);
      logic [3:0] c;
      logic thr;
      c = w[15:12];
      for (int i = 0; i < 8; i++) begin
         thr = (c == ODC_CMD_THRU_LO && i < 4) || (c == ODC_CMD_THRU_HI && i > 3)
            || c == ODC_CMD_THRU_ALL;
         if (c == ODC_CMD_RESET) begin
            m_in[i] = '0;
            m_out[i] = '0;
            m_st[i] = ODC_PWR_R100K;
         end
         if (thr || c == ODC_CMD_IN_ALL || c == 4'(i + 2)) m_in[i] = w[11:0];
         if (thr) m_out[i] = w[11:0];
         if (c == ODC_CMD_LOAD_OUT && w[4 + i]) m_out[i] = m_in[i];
         if (c == ODC_CMD_POWER && w[4 + i]) m_st[i] = w[3:2];
      end
   endfunction : apply
   function automatic logic [207:0] pack();
      logic [207:0] v;
      for (int i = 0; i < 8; i++) begin
         v[112 + i * 12 +: 12] = m_in[i];
         v[16 + i * 12 +: 12] = m_out[i];
         v[i * 2 +: 2] = m_st[i];
      end
      return v;
   endfunction : pack
   task automatic send(input logic [15:0] w, input bit ex);
      wr(2'h0, w);
      wait_idle();
      repeat (10) @(posedge mclk);
      if (ex) begin
         apply(w);
         q.push_back(pack());
      end
   endtask : send
   task automatic bang(input logic [15:0] w, input int n);
      lb.cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         lb.din <= w[15 - i];
         lb.sclk <= 1'b1;
         repeat (4) @(posedge mclk);
         lb.sclk <= 1'b0;
         repeat (4) @(posedge mclk);
      end
      lb.sclk <= 1'b1;
      lb.din <= ~lb.din;
      repeat (4) @(posedge mclk);
      lb.cs_n <= 1'b1;
      repeat (12) @(posedge mclk);
   endtask : bang
   initial begin
      forever begin
         @(posedge mclk);
         if (q.size() > 0) chk({id, od, st}, q.pop_front());
      end
   end
   initial begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      $display("MISMATCH t=%0t run too long", $time);
      tally_and_finish();
   end
   initial begin
      rst_n = 1'b0;
      wr_s = 1'b0;
      rd_s = 1'b0;
      addr = '0;
      wdata = '0;
      lb.cs_n = 1'b1;
      lb.sclk = 1'b1;
      lb.din = 1'b0;
      lb.clear_n_input = 1'b1;
      void'($urandom(32'h33ca6422));
      apply({ODC_CMD_RESET, 12'h000});
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      q.push_back(pack());
      for (int c = 0; c < 16; c++) send({c[3:0], 12'($urandom())}, 1'b1);
      $display("test commands done");
      for (int m = 0; m < 4; m++) send({ODC_CMD_POWER, 8'($urandom()), m[1:0], 2'b11}, 1'b1);
      for (int r = 0; r < 24; r++) send(16'($urandom()), 1'b1);
      $display("test random done");
      wr(2'h1, 16'h0002);
      rd(2'h1, rv);
      chk_rd(rv, 16'h0002);
      // downstream slot first, then this device's own word, select held low
      send({ODC_CMD_NOP, 12'h5a5}, 1'b0);
      cw = {ODC_CMD_THRU_ALL, 12'($urandom())};
      wr(2'h0, cw);
      wr(2'h1, 16'h0000);
      wait_idle();
      repeat (10) @(posedge mclk);
      apply(cw);
      q.push_back(pack());
      rd(2'h3, rv);
      chk_rd(rv, {ODC_CMD_NOP, 12'h5a5});
      $display("test chain done");
      wr(2'h0, {ODC_CMD_THRU_ALL, 12'hfff});
      repeat (30) @(posedge mclk);
      wr(2'h1, 16'h0001);
      wr(2'h1, 16'h0000);
      wait_idle();
      repeat (10) @(posedge mclk);
      apply({ODC_CMD_RESET, 12'h000});
      q.push_back(pack());
      $display("test clear done");
      bang({ODC_CMD_IN1, 12'habc}, 16);
      bang({ODC_CMD_THRU_ALL, 12'h123}, 15);
      chk({id_b, od_b, st_b}, {84'h0, 12'habc, 96'h0, 16'h0});
      $display("test short frame done");
      repeat (20) @(posedge mclk);
      tally_and_finish();
   end
endmodule : octal_dac_serial_control_tb
